// ==== verilog/miv_pkg.sv ====
// constants for the maskable interrupt vector and priority block
// assumes every peripheral flag arrives on the system clock domain
package miv_pkg;

    // number of maskable source groups, highest priority first
    localparam int unsigned NGRP = 14;
    localparam int unsigned GRP_IDX_W = 4;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned PRIO_W = 8;
    localparam int unsigned FLAG_TOTAL = 56;

    // group indices
    localparam int unsigned G_T1_CH0 = 0;
    localparam int unsigned G_T1_VEC = 1;   // second_timer_vector_word
    localparam int unsigned G_T2_CH0 = 2;
    localparam int unsigned G_T2_VEC = 3;   // third_timer_vector_word
    localparam int unsigned G_T3_CH0 = 4;
    localparam int unsigned G_T3_VEC = 5;   // fourth_timer_vector_word
    localparam int unsigned G_RTC = 6;
    localparam int unsigned G_WDT = 7;
    localparam int unsigned G_A0 = 8;       // serial_a0_vector_word
    localparam int unsigned G_A1 = 9;       // serial_a1_vector_word
    localparam int unsigned G_B0 = 10;      // serial_b0_vector_word
    localparam int unsigned G_ADC = 11;     // converter_vector_word
    localparam int unsigned G_P1 = 12;      // port1_vector_word
    localparam int unsigned G_P2 = 13;      // port2_vector_word

    // flag count and position of each group in the flat flag bus
    localparam int unsigned GRP_W [NGRP] = '{1, 3, 1, 2, 1, 2, 1, 1, 4, 4, 14, 6, 8, 8};
    localparam int unsigned GRP_OFS [NGRP] = '{0, 1, 4, 5, 7, 8, 10, 11, 12, 16, 20, 34, 40, 48};

    // vector word addresses
    localparam logic [ADDR_W-1:0] VEC_ADDR [NGRP] = '{
        16'hfff4, 16'hfff2, 16'hfff0, 16'hffee, 16'hffec, 16'hffea, 16'hffe8,
        16'hffe6, 16'hffe4, 16'hffe2, 16'hffe0, 16'hffde, 16'hffdc, 16'hffda};

    // fixed priority numbers, larger is served first
    localparam logic [PRIO_W-1:0] PRIO [NGRP] = '{
        8'h3a, 8'h39, 8'h38, 8'h37, 8'h36, 8'h35, 8'h34,
        8'h33, 8'h32, 8'h31, 8'h30, 8'h2f, 8'h2e, 8'h2d};

    // flags kept in spi mode: receive and transmit in the two low bits
    localparam logic [3:0] SER_A_SPI_MASK = 4'h3;
    localparam logic [13:0] SER_B_SPI_MASK = 14'h0003;

    // vector word value step per flag position
    localparam logic [15:0] VEC_WORD_STEP = 16'h0002;

    // acceptance sequencer
    typedef enum logic [0:0] {
        MIV_IDLE = 1'b0,
        MIV_FETCH = 1'b1
    } miv_state_t;

endpackage

// ==== verilog/miv_flag_group.sv ====
// one source group: masks its flags and forms its vector word value
// assumes flags are levels held by the peripheral until it clears them
`timescale 1ns/1ps
`default_nettype none
module miv_flag_group #(
    parameter int unsigned W = 1
) (
    // flags and per-flag allow mask
    input wire logic [W-1:0] flags,
    input wire logic [W-1:0] allow,
    // group result
    output logic pending,
    output logic [15:0] word
);
    import miv_pkg::*;

    logic [W-1:0] live;

    // only flags allowed by the current mode count
    assign live = flags & allow;
    assign pending = |live;

    // lowest flag position wins; value is twice its position plus two
    always_comb begin
        word = 16'h0000;
        for (int i = W - 1; i >= 0; i--) begin
            if (live[i]) begin
                word = VEC_WORD_STEP * (16'(i) + 16'h0001);
            end
        end
    end

endmodule
`default_nettype wire

// ==== verilog/miv_controller.sv ====
// maskable interrupt vector and priority controller
// assumes all flags and cpu handshakes are on the system clock
// Summary of operation
// - accepted request fetches the 16-bit handler address from its vector word
// - second timer: channel 0 at fff4h prio 58, others share fff2h prio 57
// - third timer: channel 0 at fff0h, channel 1 and overflow share ffeeh prio 55
// - fourth timer: channel 0 at ffech, channel 1 and overflow share ffeah prio 53
// - watchdog interval flag requests through ffe6h at priority 51
// - serial a0 at ffe4h prio 50; uart four flags, spi only receive/transmit
// - serial a1 same mode flag set, vector ffe2h, priority 49
// - serial b0 at ffe0h prio 48; spi two flags, i2c fourteen flags
// - converter's six flags form one request at priority 47
// - port 1 eight pin flags form one request at ffdch prio 46
// - port 2 eight pin flags at ffdah, prio 45, lowest of all
`timescale 1ns/1ps
`default_nettype none
module miv_controller (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // source flags, one bus per peripheral
    input wire logic [3:0] second_timer_flags,   // ch0, then ch1, ch2, overflow in [3:1]
    input wire logic [2:0] third_timer_flags,    // ch0, ch1, overflow
    input wire logic [2:0] fourth_timer_flags,   // ch0, ch1, overflow
    input wire logic realtime_counter_flag,
    input wire logic watchdog_interval_flag,
    input wire logic [3:0] serial_a0_flags,      // rx, tx, start, tx complete
    input wire logic [3:0] serial_a1_flags,      // rx, tx, start, tx complete
    input wire logic [13:0] serial_b0_flags,     // rx0 tx0 al nack stt stp rx1..tx3 cnt bit9
    input wire logic [5:0] converter_flags,      // done, in, low, high, time ovf, ovf
    input wire logic [7:0] port1_pin_flags,
    input wire logic [7:0] port2_pin_flags,
    // modes and masks
    input wire logic serial_a0_spi_mode,
    input wire logic serial_a1_spi_mode,
    input wire logic serial_b0_i2c_mode,
    input wire logic [miv_pkg::NGRP-1:0] group_enable,
    input wire logic global_enable,
    // cpu request and accept
    output logic irq_req_q,
    output logic [miv_pkg::ADDR_W-1:0] irq_vec_addr_q,
    output logic [miv_pkg::PRIO_W-1:0] irq_prio_q,
    output logic [miv_pkg::GRP_IDX_W-1:0] irq_group_q,
    input wire logic irq_ack,
    // vector word fetch
    output logic fetch_req,
    output logic [miv_pkg::ADDR_W-1:0] fetch_addr_q,
    input wire logic fetch_ready,
    input wire logic [miv_pkg::ADDR_W-1:0] fetch_data,
    // handler result
    output logic handler_valid_q,
    output logic [miv_pkg::ADDR_W-1:0] handler_addr_q,
    output logic [miv_pkg::NGRP-1:0] served_q,
    output logic [15:0] served_word_q,
    // per-group vector word values, group g in bits [16g+15:16g]
    output logic [miv_pkg::NGRP*16-1:0] vector_words_q
);
    import miv_pkg::*;

    logic [FLAG_TOTAL-1:0] flat_flags;
    logic [FLAG_TOTAL-1:0] flat_allow;
    logic [NGRP-1:0] pending;
    logic [NGRP-1:0] req;
    logic [15:0] words [NGRP];
    logic [GRP_IDX_W-1:0] win;
    logic win_any;
    miv_state_t state_q;
    logic [NGRP-1:0] past_req_q;

    // channel 0 flags stand alone, the rest feed the shared vectors
    // packing order must follow the group offsets exactly: a stray bit here
    // would slide every later group onto its neighbour's vector
    assign flat_flags = {port2_pin_flags, port1_pin_flags, converter_flags, serial_b0_flags,
        serial_a1_flags, serial_a0_flags, watchdog_interval_flag, realtime_counter_flag,
        fourth_timer_flags[2:1], fourth_timer_flags[0], third_timer_flags[2:1],
        third_timer_flags[0], second_timer_flags[3:1], second_timer_flags[0]};

    // mode-dependent allow masks for the serial units
    always_comb begin
        flat_allow = '1;
        flat_allow[GRP_OFS[G_A0] +: 4] = serial_a0_spi_mode ? SER_A_SPI_MASK : 4'hf;
        flat_allow[GRP_OFS[G_A1] +: 4] = serial_a1_spi_mode ? SER_A_SPI_MASK : 4'hf;
        flat_allow[GRP_OFS[G_B0] +: 14] = serial_b0_i2c_mode ? 14'h3fff : SER_B_SPI_MASK;
    end

    // one flag group per source, plus its registered vector word
    for (genvar g = 0; g < NGRP; g++) begin : grp
        miv_flag_group #(.W(GRP_W[g])) u_grp (
            .flags(flat_flags[GRP_OFS[g] +: GRP_W[g]]),
            .allow(flat_allow[GRP_OFS[g] +: GRP_W[g]]),
            .pending(pending[g]),
            .word(words[g])
        );
        assign req[g] = pending[g] & group_enable[g] & global_enable;
        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                vector_words_q[16*g +: 16] <= 16'h0000;
            end else begin
                vector_words_q[16*g +: 16] <= words[g];
            end
        end
    end

    // fixed priority: lowest group index carries the highest number
    always_comb begin
        win = '0;
        win_any = 1'b0;
        for (int g = NGRP - 1; g >= 0; g--) begin
            if (req[g]) begin
                win = GRP_IDX_W'(g);
                win_any = 1'b1;
            end
        end
    end

    // registered request toward the core, dropped while a fetch runs
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            irq_req_q <= 1'b0;
            irq_vec_addr_q <= 16'h0000;
            irq_prio_q <= 8'h00;
            irq_group_q <= '0;
            past_req_q <= '0;
        end else begin
            irq_req_q <= win_any && (state_q == MIV_IDLE) && !(irq_req_q && irq_ack);
            irq_vec_addr_q <= VEC_ADDR[win];
            irq_prio_q <= PRIO[win];
            irq_group_q <= win;
            past_req_q <= req;
        end
    end

    // accept, then fetch the handler address from the vector word
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_q <= MIV_IDLE;
            fetch_addr_q <= 16'h0000;
            handler_valid_q <= 1'b0;
            handler_addr_q <= 16'h0000;
            served_q <= '0;
            served_word_q <= 16'h0000;
        end else begin
            handler_valid_q <= 1'b0;
            served_q <= '0;
            case (state_q)
                MIV_IDLE: begin
                    if (irq_req_q && irq_ack) begin
                        state_q <= MIV_FETCH;
                        fetch_addr_q <= irq_vec_addr_q;
                        served_q[irq_group_q] <= 1'b1;
                        served_word_q <= words[irq_group_q];
                    end
                end
                MIV_FETCH: begin
                    if (fetch_ready) begin
                        state_q <= MIV_IDLE;
                        handler_valid_q <= 1'b1;
                        handler_addr_q <= fetch_data;
                    end
                end
                default: begin
                    state_q <= MIV_IDLE;
                end
            endcase
        end
    end

    assign fetch_req = (state_q == MIV_FETCH);

    // checks below watch registered outputs and the internal request vector;
    // the request and winner registers share one cycle of lag, so they compare
    // against the request vector of the previous cycle
    // the fetch reads exactly the vector of the accepted group
    fetch_addr_a: assert property (@(posedge clock) disable iff (reset)
        (irq_req_q && irq_ack && state_q == MIV_IDLE) |=> fetch_req && fetch_addr_q == $past(irq_vec_addr_q))
        else $error("fetch address differs from accepted vector");

    // fetched word reaches the handler output one cycle later
    handler_word_a: assert property (@(posedge clock) disable iff (reset)
        (fetch_req && fetch_ready) |=> handler_valid_q && handler_addr_q == $past(fetch_data) ##1 !handler_valid_q)
        else $error("handler address not taken from fetched word");

    // second timer shared vector and priority
    t1_shared_a: assert property (@(posedge clock) disable iff (reset)
        (irq_req_q && irq_group_q == 4'h1) |-> irq_vec_addr_q == 16'hfff2 && irq_prio_q == 8'h39)
        else $error("second timer shared vector wrong");

    // third timer shared vector and priority
    t2_shared_a: assert property (@(posedge clock) disable iff (reset)
        (irq_req_q && irq_group_q == 4'h3) |-> irq_vec_addr_q == 16'hffee && irq_prio_q == 8'h37)
        else $error("third timer shared vector wrong");

    // fourth timer shared vector and priority
    t3_shared_a: assert property (@(posedge clock) disable iff (reset)
        (irq_req_q && irq_group_q == 4'h5) |-> irq_vec_addr_q == 16'hffea && irq_prio_q == 8'h35)
        else $error("fourth timer shared vector wrong");

    // watchdog alone and enabled gives its vector next cycle
    wdt_vector_a: assert property (@(posedge clock) disable iff (reset)
        (req == 14'h0080 && state_q == MIV_IDLE && !irq_ack) |=> irq_req_q && irq_vec_addr_q == 16'hffe6)
        else $error("watchdog vector wrong");

    // spi mode ignores start and transmit complete flags
    a0_spi_mask_a: assert property (@(posedge clock) disable iff (reset)
        (serial_a0_spi_mode && serial_a0_flags[1:0] == 2'b00) |=> vector_words_q[16*G_A0 +: 16] == 16'h0000)
        else $error("serial a0 spi mode flag mask wrong");

    // i2c mode nack flag at position three gives value eight
    b0_i2c_word_a: assert property (@(posedge clock) disable iff (reset)
        (serial_b0_i2c_mode && serial_b0_flags[3:0] == 4'h8) |=> vector_words_q[16*G_B0 +: 16] == 16'h0008)
        else $error("serial b0 i2c vector word wrong");

    // port 2 lowest: priority 45 only when no other group requested
    p2_lowest_a: assert property (@(posedge clock) disable iff (reset)
        (irq_req_q && irq_prio_q == 8'h2d) |-> past_req_q == 14'h2000 && irq_vec_addr_q == 16'hffda)
        else $error("port 2 served over a higher request");

    // no higher requesting group than the one presented
    highest_first_a: assert property (@(posedge clock) disable iff (reset)
        irq_req_q |-> (past_req_q & ((14'h0001 << irq_group_q) - 14'h0001)) == 14'h0000
        && past_req_q[irq_group_q])
        else $error("request presented is not the highest");

endmodule
`default_nettype wire

// ==== bench/miv_cpu_model.sv ====
// core-side memory model answering vector word fetches
// assumes fetch_req is high from the controller while a fetch is open
`timescale 1ns/1ps
`default_nettype none
module miv_cpu_model (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // fetch request from the controller
    input wire logic fetch_req,
    input wire logic [15:0] fetch_addr,
    input wire logic [3:0] wait_cycles,
    // memory answer
    output logic fetch_ready,
    output logic [15:0] fetch_data
);
    logic [3:0] wait_q;
    // counts stall cycles of the open fetch
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wait_q <= 4'h0;
        end else if (fetch_req && !fetch_ready) begin
            wait_q <= wait_q + 4'h1;
        end else begin
            wait_q <= 4'h0;
        end
    end
    // handler address held at each vector word; junk while not ready
    assign fetch_ready = fetch_req && (wait_q == wait_cycles);
    assign fetch_data = fetch_ready ? {fetch_addr[7:0], 8'h5a} : ~{fetch_addr[7:0], 8'h5a};
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench for the interrupt vector and priority controller
// assumes the core model answers fetches with a handler derived from the address
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fails++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module testbench;
    import miv_pkg::*;
    logic clock, reset, rtc_f, wdt_f, a0_spi, a1_spi, b0_i2c, glb, ack;
    logic [2:0] t2_f, t3_f;
    logic [3:0] t1_f, a0_f, a1_f, wcyc;
    logic [13:0] b0_f, gen;
    logic [5:0] adc_f;
    logic [7:0] p1_f, p2_f;
    logic irq_req_q, fetch_req, fetch_ready, handler_valid_q;
    logic [15:0] irq_vec_addr_q, fetch_addr_q, fetch_data, handler_addr_q, served_word_q;
    logic [7:0] irq_prio_q;
    logic [3:0] irq_group_q;
    logic [13:0] served_q;
    logic [223:0] vector_words_q;
    int fails, check_count;
    miv_controller DUT (.clock(clock), .reset(reset), .second_timer_flags(t1_f),
        .third_timer_flags(t2_f), .fourth_timer_flags(t3_f), .realtime_counter_flag(rtc_f),
        .watchdog_interval_flag(wdt_f), .serial_a0_flags(a0_f), .serial_a1_flags(a1_f),
        .serial_b0_flags(b0_f), .converter_flags(adc_f), .port1_pin_flags(p1_f),
        .port2_pin_flags(p2_f), .serial_a0_spi_mode(a0_spi), .serial_a1_spi_mode(a1_spi),
        .serial_b0_i2c_mode(b0_i2c), .group_enable(gen), .global_enable(glb),
        .irq_req_q(irq_req_q), .irq_vec_addr_q(irq_vec_addr_q), .irq_prio_q(irq_prio_q),
        .irq_group_q(irq_group_q), .irq_ack(ack), .fetch_req(fetch_req),
        .fetch_addr_q(fetch_addr_q), .fetch_ready(fetch_ready), .fetch_data(fetch_data),
        .handler_valid_q(handler_valid_q), .handler_addr_q(handler_addr_q),
        .served_q(served_q), .served_word_q(served_word_q), .vector_words_q(vector_words_q));
    miv_cpu_model core (.clock(clock), .reset(reset), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr_q), .wait_cycles(wcyc), .fetch_ready(fetch_ready),
        .fetch_data(fetch_data));
    // system clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // prints the counts and the verdict, then stops
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // raises the lowest flag of group g, or clears the whole group
    task automatic set_flag(input int g, input logic v);
        case (g)
            0: t1_f[0] = v;
            1: t1_f[3:1] = {2'b00, v};
            2: t2_f[0] = v;
            3: t2_f[2:1] = {1'b0, v};
            4: t3_f[0] = v;
            5: t3_f[2:1] = {1'b0, v};
            6: rtc_f = v;
            7: wdt_f = v;
            8: a0_f = {3'h0, v};
            9: a1_f = {3'h0, v};
            10: b0_f = {13'h0, v};
            11: adc_f = {5'h0, v};
            12: p1_f = {7'h0, v};
            default: p2_f = {7'h0, v};
        endcase
    endtask
    // waits for a request, accepts it and checks the fetched handler
    task automatic serve(input int g, input logic [15:0] w);
        int n;
        n = 0;
        wcyc = 4'(g % 3);
        while (irq_req_q !== 1'b1 && n < 20) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (irq_req_q !== 1'b1) begin
            fails++;
            wrap_up();
        end
        `CHK("group", 4'(g), irq_group_q)
        `CHK("vector", 16'hfff4 - 16'(2 * g), irq_vec_addr_q)
        `CHK("prio", 8'(58 - g), irq_prio_q)
        ack = 1'b1;
        @(posedge clock);
        #1;
        ack = 1'b0;
        `CHK("served", 14'(1 << g), served_q)
        `CHK("word", w, served_word_q)
        `CHK("fetch_addr", 16'hfff4 - 16'(2 * g), fetch_addr_q)
        n = 0;
        while (handler_valid_q !== 1'b1 && n < 20) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (handler_valid_q !== 1'b1) begin
            fails++;
            wrap_up();
        end
        `CHK("handler", {8'(16'hfff4 - 16'(2 * g)), 8'h5a}, handler_addr_q)
        set_flag(g, 1'b0);
    endtask
    // waits three cycles, then checks once that nothing is requested
    task automatic quiet();
        repeat (3) @(posedge clock);
        #1;
        `CHK("no_req", 1'b0, irq_req_q)
    endtask
    // main sequence
    initial begin
        {t1_f, t2_f, t3_f, rtc_f, wdt_f, a0_f, a1_f, b0_f, adc_f, p1_f, p2_f} = '0;
        {a0_spi, a1_spi, b0_i2c, ack, wcyc} = '0;
        gen = '1;
        glb = 1'b1;
        fails = 0;
        check_count = 0;
        reset = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        reset = 1'b0;
        // all groups at once: served strictly by priority
        for (int g = 0; g < 14; g++) set_flag(g, 1'b1);
        for (int g = 0; g < 14; g++) serve(g, 16'h0002);
        // per-group mask and global mask
        p1_f = 8'h08;
        gen[12] = 1'b0;
        quiet();
        `CHK("p1_word", 16'h0008, vector_words_q[12*16+:16])
        gen[12] = 1'b1;
        serve(12, 16'h0008);
        glb = 1'b0;
        p2_f = 8'h80;
        quiet();
        glb = 1'b1;
        serve(13, 16'h0010);
        // serial modes: start and tx complete flags only count in uart mode, upper b0 flags only in i2c mode
        a0_spi = 1'b1;
        a1_spi = 1'b1;
        a0_f = 4'h4;
        a1_f = 4'h8;
        quiet();
        a0_spi = 1'b0;
        serve(8, 16'h0006);
        a1_spi = 1'b0;
        serve(9, 16'h0008);
        b0_f = 14'h2000;
        quiet();
        b0_i2c = 1'b1;
        serve(10, 16'h001c);
        adc_f = 6'h20;
        serve(11, 16'h000c);
        // i2c nack alone, watchdog alone, then the shared timer vectors
        b0_f = 14'h0008;
        serve(10, 16'h0008);
        wdt_f = 1'b1;
        serve(7, 16'h0002);
        t1_f = 4'h8;
        serve(1, 16'h0006);
        t2_f = 3'h4;
        serve(3, 16'h0004);
        t3_f = 3'h4;
        serve(5, 16'h0004);
        wrap_up();
    end
endmodule
`default_nettype wire
